// ===== lptfc_ctl_if.sv
// Interface joining the register side to the flag and wake logic.
// Assumes all three parties run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface lptfc_ctl_if;
    logic [lptfc_pkg::NUM_FLAGS-1:0] clr;
    logic [lptfc_pkg::NUM_FLAGS-1:0] flags;
    logic cmp_wake_en;
    logic trig_irq_en;

    modport regs (
        output clr,
        output cmp_wake_en,
        output trig_irq_en,
        input flags
    );

    modport flg (
        input clr,
        input cmp_wake_en,
        output flags
    );

    modport wk (
        input flags,
        input cmp_wake_en,
        input trig_irq_en
    );
endinterface
`default_nettype wire

// ===== lptfc_flags.sv
// Status flags of the timer, set by timer events and cleared by command.
// Assumes event inputs are one-cycle pulses synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module lptfc_flags (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic overflow_evt,
    input wire logic repetition_zero,
    input wire logic compare_match_evt,
    input wire logic trigger_edge_evt,
    lptfc_ctl_if.flg ctl
);
    typedef struct packed {
        logic [lptfc_pkg::NUM_FLAGS-1:0] flags;
    } lptfc_flg_state_type;

    lptfc_flg_state_type st_ff;
    lptfc_flg_state_type nxt_st;
    logic [lptfc_pkg::NUM_FLAGS-1:0] set_vec;
    logic [lptfc_pkg::NUM_FLAGS-1:0] nxt_flags;

    // ==========================================================
    // Event sources
    always_comb
    begin
        set_vec = '0;
        set_vec[lptfc_pkg::F_UPDATE] = overflow_evt & repetition_zero;
        set_vec[lptfc_pkg::F_OVERFLOW] = overflow_evt;
        set_vec[lptfc_pkg::F_COMPARE] = compare_match_evt;
        set_vec[lptfc_pkg::F_TRIGGER] = trigger_edge_evt;
        set_vec[lptfc_pkg::F_WAKE] = compare_match_evt & ctl.cmp_wake_en;
    end

    // ==========================================================
    // Set wins over clear so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < lptfc_pkg::NUM_FLAGS; gi++)
        begin : g_flag
            assign nxt_flags[gi] = set_vec[gi] | (st_ff.flags[gi] & ~ctl.clr[gi]);
        end
    endgenerate

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.flags = nxt_flags;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= '{flags: lptfc_pkg::FLAGS_RESET};
        else
            st_ff <= nxt_st;
    end

    assign ctl.flags = st_ff.flags;
endmodule
`default_nettype wire

// ===== lptfc_pkg.sv
// Package for the low-power timer flag-clear and enable block.
// Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
package lptfc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFF_STATUS = 12'h000;
    localparam logic [11:0] OFF_FLAG_CLEAR = 12'h004;
    localparam logic [11:0] OFF_IRQ_WAKE_EN = 12'h008;

    // ==========================================================
    // Flag-clear and status field positions
    localparam int BIT_UPDATE = 0;
    localparam int BIT_OVERFLOW = 1;
    localparam int BIT_COMPARE = 2;
    localparam int BIT_TRIGGER = 3;
    localparam int BIT_WAKE = 8;

    // Enable register field positions
    localparam int BIT_TRIG_IRQ_EN = 3;
    localparam int BIT_CMP_WAKE_EN = 10;

    // ==========================================================
    // Internal flag vector indices
    localparam int NUM_FLAGS = 5;
    localparam int F_UPDATE = 0;
    localparam int F_OVERFLOW = 1;
    localparam int F_COMPARE = 2;
    localparam int F_TRIGGER = 3;
    localparam int F_WAKE = 4;

    // ==========================================================
    // Reset values and responses
    localparam logic EN_RESET = 1'h0;
    localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 5'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Bus state machines
    typedef enum logic [1:0] {
        WR_COLLECT = 2'h1,
        WR_RESP = 2'h2
    } lptfc_wr_state_type;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_DATA = 2'h2
    } lptfc_rd_state_type;

endpackage

// ===== lptfc_top.sv
// Flag-clear command and interrupt/wakeup enable registers of the timer,
// reached over AXI4-Lite, with the status flags they act upon.
// Assumes timer events arrive as one-cycle pulses on aclk.
`timescale 1ns/1ps
`default_nettype none
module lptfc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [lptfc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [lptfc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [lptfc_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [lptfc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [lptfc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic overflow_evt,
    input wire logic repetition_zero,
    input wire logic compare_match_evt,
    input wire logic trigger_edge_evt,
    output logic [lptfc_pkg::DATA_W-1:0] timer_status_register,
    output logic irq_out,
    output logic wake_out
);

    // ==========================================================
    // State
    typedef struct packed {
        lptfc_pkg::lptfc_wr_state_type wr_state;
        lptfc_pkg::lptfc_rd_state_type rd_state;
        logic aw_got;
        logic [lptfc_pkg::ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [lptfc_pkg::DATA_W-1:0] w_data;
        logic [lptfc_pkg::STRB_W-1:0] w_strb;
        logic [1:0] b_resp;
        logic [lptfc_pkg::DATA_W-1:0] r_data;
        logic [1:0] r_resp;
        logic [lptfc_pkg::NUM_FLAGS-1:0] clr_pulse;
        logic cmp_wake_en;
        logic trig_irq_en;
    } lptfc_regs_type;

    localparam lptfc_regs_type REGS_RESET = '{
        wr_state: lptfc_pkg::WR_COLLECT,
        rd_state: lptfc_pkg::RD_IDLE,
        cmp_wake_en: lptfc_pkg::EN_RESET,
        trig_irq_en: lptfc_pkg::EN_RESET,
        default: '0
    };

    lptfc_regs_type st_ff;
    lptfc_regs_type nxt_st;

    lptfc_ctl_if ctl ();

    logic [lptfc_pkg::ADDR_W-1:0] wr_addr;
    logic [lptfc_pkg::DATA_W-1:0] wr_data;
    logic [lptfc_pkg::STRB_W-1:0] wr_strb;
    logic [lptfc_pkg::DATA_W-1:0] status_word;
    logic [lptfc_pkg::DATA_W-1:0] enable_word;

    // ==========================================================
    // Status word as software sees it
    always_comb
    begin
        status_word = '0;
        status_word[lptfc_pkg::BIT_UPDATE] = ctl.flags[lptfc_pkg::F_UPDATE];
        status_word[lptfc_pkg::BIT_OVERFLOW] = ctl.flags[lptfc_pkg::F_OVERFLOW];
        status_word[lptfc_pkg::BIT_COMPARE] = ctl.flags[lptfc_pkg::F_COMPARE];
        status_word[lptfc_pkg::BIT_TRIGGER] = ctl.flags[lptfc_pkg::F_TRIGGER];
        status_word[lptfc_pkg::BIT_WAKE] = ctl.flags[lptfc_pkg::F_WAKE];
    end

    // Reserved enable bits always read zero
    always_comb
    begin
        enable_word = '0;
        enable_word[lptfc_pkg::BIT_CMP_WAKE_EN] = st_ff.cmp_wake_en;
        enable_word[lptfc_pkg::BIT_TRIG_IRQ_EN] = st_ff.trig_irq_en;
    end

    // ==========================================================
    // Write channel: address and data in either order
    assign s_axi_awready = (st_ff.wr_state == lptfc_pkg::WR_COLLECT) && !st_ff.aw_got;
    assign s_axi_wready = (st_ff.wr_state == lptfc_pkg::WR_COLLECT) && !st_ff.w_got;
    assign s_axi_bvalid = (st_ff.wr_state == lptfc_pkg::WR_RESP);
    assign s_axi_bresp = st_ff.b_resp;

    // Same-cycle bypass lets a paired offer finish in one edge
    assign wr_addr = st_ff.aw_got ? st_ff.aw_addr : s_axi_awaddr;
    assign wr_data = st_ff.w_got ? st_ff.w_data : s_axi_wdata;
    assign wr_strb = st_ff.w_got ? st_ff.w_strb : s_axi_wstrb;

    // ==========================================================
    // Read channel
    assign s_axi_arready = (st_ff.rd_state == lptfc_pkg::RD_IDLE);
    assign s_axi_rvalid = (st_ff.rd_state == lptfc_pkg::RD_DATA);
    assign s_axi_rdata = st_ff.r_data;
    assign s_axi_rresp = st_ff.r_resp;

    // ==========================================================
    // Next state
    always_comb
    begin
        logic aw_have;
        logic w_have;
        aw_have = 1'b0;
        w_have = 1'b0;
        nxt_st = st_ff;
        // Clear commands live for one cycle only
        nxt_st.clr_pulse = '0;

        case (st_ff.wr_state)
            lptfc_pkg::WR_COLLECT:
            begin
                aw_have = st_ff.aw_got || s_axi_awvalid;
                w_have = st_ff.w_got || s_axi_wvalid;
                if (s_axi_awvalid && !st_ff.aw_got)
                begin
                    nxt_st.aw_got = 1'b1;
                    nxt_st.aw_addr = s_axi_awaddr;
                end
                if (s_axi_wvalid && !st_ff.w_got)
                begin
                    nxt_st.w_got = 1'b1;
                    nxt_st.w_data = s_axi_wdata;
                    nxt_st.w_strb = s_axi_wstrb;
                end
                if (aw_have && w_have)
                begin
                    nxt_st.aw_got = 1'b0;
                    nxt_st.w_got = 1'b0;
                    nxt_st.wr_state = lptfc_pkg::WR_RESP;
                    nxt_st.b_resp = lptfc_pkg::RESP_OKAY;
                    if ({wr_addr[lptfc_pkg::ADDR_W-1:2], 2'b00} ==
                        lptfc_pkg::OFF_FLAG_CLEAR)
                    begin
                        if (wr_strb[0])
                        begin
                            nxt_st.clr_pulse[lptfc_pkg::F_UPDATE] =
                                wr_data[lptfc_pkg::BIT_UPDATE];
                            nxt_st.clr_pulse[lptfc_pkg::F_OVERFLOW] =
                                wr_data[lptfc_pkg::BIT_OVERFLOW];
                            nxt_st.clr_pulse[lptfc_pkg::F_COMPARE] =
                                wr_data[lptfc_pkg::BIT_COMPARE];
                            nxt_st.clr_pulse[lptfc_pkg::F_TRIGGER] =
                                wr_data[lptfc_pkg::BIT_TRIGGER];
                        end
                        if (wr_strb[1])
                        begin
                            nxt_st.clr_pulse[lptfc_pkg::F_WAKE] =
                                wr_data[lptfc_pkg::BIT_WAKE];
                        end
                    end
                    else if ({wr_addr[lptfc_pkg::ADDR_W-1:2], 2'b00} ==
                        lptfc_pkg::OFF_IRQ_WAKE_EN)
                    begin
                        // Upper bits are simply not stored
                        if (wr_strb[0])
                        begin
                            nxt_st.trig_irq_en = wr_data[lptfc_pkg::BIT_TRIG_IRQ_EN];
                        end
                        if (wr_strb[1])
                        begin
                            nxt_st.cmp_wake_en = wr_data[lptfc_pkg::BIT_CMP_WAKE_EN];
                        end
                    end
                    else if ({wr_addr[lptfc_pkg::ADDR_W-1:2], 2'b00} ==
                        lptfc_pkg::OFF_STATUS)
                    begin
                        // Read-only; write accepted and dropped
                        nxt_st.b_resp = lptfc_pkg::RESP_OKAY;
                    end
                    else
                    begin
                        nxt_st.b_resp = lptfc_pkg::RESP_SLVERR;
                    end
                end
            end
            lptfc_pkg::WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    nxt_st.wr_state = lptfc_pkg::WR_COLLECT;
                end
            end
            default:
            begin
                nxt_st.wr_state = lptfc_pkg::WR_COLLECT;
            end
        endcase

        case (st_ff.rd_state)
            lptfc_pkg::RD_IDLE:
            begin
                if (s_axi_arvalid)
                begin
                    nxt_st.rd_state = lptfc_pkg::RD_DATA;
                    nxt_st.r_resp = lptfc_pkg::RESP_OKAY;
                    if ({s_axi_araddr[lptfc_pkg::ADDR_W-1:2], 2'b00} ==
                        lptfc_pkg::OFF_STATUS)
                    begin
                        nxt_st.r_data = status_word;
                    end
                    else if ({s_axi_araddr[lptfc_pkg::ADDR_W-1:2], 2'b00} ==
                        lptfc_pkg::OFF_FLAG_CLEAR)
                    begin
                        nxt_st.r_data = '0;
                    end
                    else if ({s_axi_araddr[lptfc_pkg::ADDR_W-1:2], 2'b00} ==
                        lptfc_pkg::OFF_IRQ_WAKE_EN)
                    begin
                        nxt_st.r_data = enable_word;
                    end
                    else
                    begin
                        nxt_st.r_data = '0;
                        nxt_st.r_resp = lptfc_pkg::RESP_SLVERR;
                    end
                end
            end
            lptfc_pkg::RD_DATA:
            begin
                if (s_axi_rready)
                begin
                    nxt_st.rd_state = lptfc_pkg::RD_IDLE;
                end
            end
            default:
            begin
                nxt_st.rd_state = lptfc_pkg::RD_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= REGS_RESET;
        else
            st_ff <= nxt_st;
    end

    // ==========================================================
    // Connections to flag and wake logic
    assign ctl.clr = st_ff.clr_pulse;
    assign ctl.cmp_wake_en = st_ff.cmp_wake_en;
    assign ctl.trig_irq_en = st_ff.trig_irq_en;

    // Flags are flops inside the flag module
    assign timer_status_register = status_word;

    lptfc_flags u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .overflow_evt(overflow_evt),
        .repetition_zero(repetition_zero),
        .compare_match_evt(compare_match_evt),
        .trigger_edge_evt(trigger_edge_evt),
        .ctl(ctl.flg)
    );

    lptfc_wake u_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctl(ctl.wk),
        .irq_out(irq_out),
        .wake_out(wake_out)
    );

endmodule
`default_nettype wire

// ===== lptfc_top_assertions.sv
// Concurrent checks on the ports of the flag-clear and enable block.
// Assumes binding to lptfc_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lptfc_top_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic overflow_evt,
    input wire logic repetition_zero,
    input wire logic compare_match_evt,
    input wire logic trigger_edge_evt,
    input wire logic [31:0] timer_status_register,
    input wire logic irq_out,
    input wire logic wake_out
);
    // ==========================================================
    // Helpers
    // Both channels taken together, as the bench always offers them
    logic wr_go;
    logic fc;
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign fc = wr_go && s_axi_awaddr == lptfc_pkg::OFF_FLAG_CLEAR;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // Properties
    property p_wr_unmapped;
        wr_go && !(s_axi_awaddr inside {12'h000, 12'h004, 12'h008})
            |=> s_axi_bvalid && s_axi_bresp == lptfc_pkg::RESP_SLVERR;
    endproperty
    a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write not refused");
    // Clear needs a quiet cycle: a set in the clear cycle wins
    property p_clr_wake;
        fc && s_axi_wdata[8] && s_axi_wstrb[1] ##1 !compare_match_evt
            |=> !timer_status_register[8];
    endproperty
    a_clr_wake: assert property (p_clr_wake) else $error("wake flag not cleared");
    property p_clr_trig;
        fc && s_axi_wdata[3] && s_axi_wstrb[0] ##1 !trigger_edge_evt
            |=> !timer_status_register[3];
    endproperty
    a_clr_trig: assert property (p_clr_trig) else $error("trigger flag not cleared");
    property p_clr_cmp;
        fc && s_axi_wdata[2] && s_axi_wstrb[0] ##1 !compare_match_evt
            |=> !timer_status_register[2];
    endproperty
    a_clr_cmp: assert property (p_clr_cmp) else $error("compare flag not cleared");
    property p_clr_ovf;
        fc && s_axi_wdata[1] && s_axi_wstrb[0] ##1 !overflow_evt
            |=> !timer_status_register[1];
    endproperty
    a_clr_ovf: assert property (p_clr_ovf) else $error("overflow flag not cleared");
    property p_clr_upd;
        fc && s_axi_wdata[0] && s_axi_wstrb[0] ##1 !(overflow_evt && repetition_zero)
            |=> !timer_status_register[0];
    endproperty
    a_clr_upd: assert property (p_clr_upd) else $error("update flag not cleared");
    property p_wake_follow;
        1'h1 |=> wake_out == $past(timer_status_register[8]);
    endproperty
    a_wake_follow: assert property (p_wake_follow) else $error("wake output wrong");
    property p_irq_gate;
        !timer_status_register[3] |=> !irq_out;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without trigger flag");
    property p_en_rsvd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == lptfc_pkg::OFF_IRQ_WAKE_EN
            |=> s_axi_rvalid && s_axi_rdata[31:11] == 21'h00000;
    endproperty
    a_en_rsvd: assert property (p_en_rsvd) else $error("reserved enable bits read back");
    property p_upd_set;
        // A clear taken in the same cycle may end the flag early
        overflow_evt && repetition_zero && !(fc && s_axi_wdata[0])
            |=> timer_status_register[0] [*2];
    endproperty
    a_upd_set: assert property (p_upd_set) else $error("update flag not set");
    property p_zero_keeps;
        fc && !s_axi_wdata[2] && timer_status_register[2] |-> ##2 timer_status_register[2];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero bit cleared a flag");

    // ==========================================================
    // Coverage
    c_clear: cover property (fc);
    c_update: cover property (overflow_evt && repetition_zero);
    c_outputs: cover property (irq_out && wake_out);
endmodule

bind lptfc_top lptfc_top_assertions u_chk (.*);
`default_nettype wire

// ===== lptfc_top_tb.sv
// Self-checking bench for lptfc_top, driven over AXI4-Lite.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`default_nettype none
module lptfc_top_tb;
    // ==========================================================
    // Signals
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [2:0] s_axi_awprot = 3'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'h0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [2:0] s_axi_arprot = 3'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'h0;
    logic overflow_evt = 1'h0;
    logic repetition_zero = 1'h0;
    logic compare_match_evt = 1'h0;
    logic trigger_edge_evt = 1'h0;
    logic [31:0] timer_status_register;
    logic irq_out;
    logic wake_out;
    int mismatches = 0;
    int check_count = 0;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    int bit_pos[5] = '{0, 1, 2, 3, 8};
    logic [31:0] d;
    logic [31:0] st;

    lptfc_top uut (.*);

    always #50 aclk = ~aclk;

    // ==========================================================
    // Tasks
    task automatic check(input string name, input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] r);
        wr_q.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [33:0] exp);
        rd_q.push_back(exp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'h0;
    endtask

    // One-cycle timer event pulses: trigger, compare, overflow, repetition zero
    task automatic ev(input logic [3:0] v);
        @(posedge aclk);
        {trigger_edge_evt, compare_match_evt, overflow_evt, repetition_zero} <= v;
        @(posedge aclk);
        {trigger_edge_evt, compare_match_evt, overflow_evt, repetition_zero} <= 4'h0;
    endtask

    // ==========================================================
    // Response monitor
    always @(posedge aclk)
    begin
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", s_axi_bresp, wr_q.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            check("rdata", {s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(94));
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rd(12'h000, 34'h0);
        rd(12'h004, 34'h0);
        rd(12'h008, 34'h0);
        repeat (4)
        begin
            d = $urandom;
            wr(12'h008, d, 4'hF, lptfc_pkg::RESP_OKAY);
            rd(12'h008, {2'h0, d & 32'h00000408});
        end
        wr(12'h008, 32'h00000408, 4'hF, lptfc_pkg::RESP_OKAY);
        // Reserved bits random, so they must not disturb other flags
        foreach (bit_pos[i])
        begin
            ev(4'hF);
            rd(12'h000, {2'h0, 32'h0000010F});
            check("irq", irq_out, 1'h1);
            d = ($urandom & 32'hFFFFFEF0) | (32'h00000001 << bit_pos[i]);
            wr(12'h004, d, 4'hF, lptfc_pkg::RESP_OKAY);
            st = 32'h0000010F & ~(32'h00000001 << bit_pos[i]);
            rd(12'h000, {2'h0, st});
            check("status", timer_status_register, {2'h0, st});
            check("irq", irq_out, st[3]);
            check("wake", wake_out, st[8]);
        end
        wr(12'h004, 32'h0000010F, 4'h0, lptfc_pkg::RESP_OKAY);
        rd(12'h000, {2'h0, 32'h0000000F});
        wr(12'h004, 32'h0000010F, 4'hF, lptfc_pkg::RESP_OKAY);
        rd(12'h000, 34'h0);
        // Repetition zero alone must not set the update flag
        ev(4'h1);
        ev(4'h2);
        rd(12'h000, {2'h0, 32'h00000002});
        ev(4'h3);
        rd(12'h000, {2'h0, 32'h00000003});
        wr(12'h008, 32'h00000000, 4'hF, lptfc_pkg::RESP_OKAY);
        ev(4'h4);
        ev(4'h8);
        rd(12'h000, {2'h0, 32'h0000000F});
        check("wake", wake_out, 1'h0);
        check("irq", irq_out, 1'h0);
        wr(12'h00C, $urandom, 4'hF, lptfc_pkg::RESP_SLVERR);
        rd(12'h00C, {lptfc_pkg::RESP_SLVERR, 32'h00000000});
        wr(12'h000, 32'h00000000, 4'hF, lptfc_pkg::RESP_OKAY);
        rd(12'h000, {2'h0, 32'h0000000F});
        rd(12'h004, 34'h0);
        repeat (4) @(posedge aclk);
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== lptfc_wake.sv
// Interrupt output gated by the enable register; wakeup output follows the wake flag.
// Assumes flags are held until software clears them.
`timescale 1ns/1ps
`default_nettype none
module lptfc_wake (
    input wire logic aclk,
    input wire logic aresetn,
    lptfc_ctl_if.wk ctl,
    output logic irq_out,
    output logic wake_out
);
    typedef struct packed {
        logic irq;
        logic wake;
    } lptfc_wk_state_type;

    lptfc_wk_state_type st_ff;
    lptfc_wk_state_type nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.irq = ctl.flags[lptfc_pkg::F_TRIGGER] & ctl.trig_irq_en;
        nxt_st.wake = ctl.flags[lptfc_pkg::F_WAKE];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= '{irq: 1'b0, wake: 1'b0};
        else
            st_ff <= nxt_st;
    end

    assign irq_out = st_ff.irq;
    assign wake_out = st_ff.wake;
endmodule
`default_nettype wire
